// [logic/cmp_event_pkg.sv]
// Constants and types for the comparator event logic
// How it works
// (R01) Source 00 samples comparator every clock
// (R02) Three debounce modes, edge modes only
// (R03) Debounce with source 00 uses Timer 1
// (R04) Resample after two Timer 1 overflows
// (R05) Matching resample sets flag, else discarded
// (R06) Flag lands one to two periods later
// (R07) Timer sampling needs four stable samples
// (R08) Connect bit drives analog input connection
// (R09) Software disconnects before changing muxes
// (R10) Mode condition plus enable sets flag
// (R11) Only software clears the event flag
// (R12) Interrupt enable bit 6 gates request
// (R13) Disabled forces output low, blocks flag
// (R14) Enabled makes analog pins input only
// (R15) Control register index 97h, resets zero
// (R16) Output high when positive input exceeds
// (R17) Source field picks clock or timer overflow
// (R18) Mode field encodes eight flag conditions
// (R19) Channel select picks inputs zero to three
package cmp_event_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [7:0] CTRL_IDX = 8'h97;
    localparam logic [7:0] REF_IDX = 8'h98;
    localparam logic [7:0] STAT_IDX = 8'h99;
    localparam logic [7:0] CLR_IDX = 8'h9a;
    localparam logic [7:0] IE_IDX = 8'h9b;
    localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
    localparam logic [11:0] REF_ADDR = {2'h0, REF_IDX, 2'h0};
    localparam logic [11:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};
    localparam logic [11:0] CLR_ADDR = {2'h0, CLR_IDX, 2'h0};
    localparam logic [11:0] IE_ADDR = {2'h0, IE_IDX, 2'h0};
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] REF_RESET = 8'h00;
    localparam logic [7:0] IE_RESET = 8'h00;
    localparam int FLAG_BIT = 4;
    localparam int IRQ_CMP_BIT = 6;
    localparam int IRQ_REJ_BIT = 0;
    localparam logic [1:0] SRC_CLOCK = 2'h0;
    localparam logic [1:0] SRC_TIMER0 = 2'h1;
    localparam logic [1:0] SRC_TIMER1 = 2'h2;
    localparam logic [1:0] SRC_TIMER2 = 2'h3;
    localparam logic [2:0] MODE_LOW = 3'h0;
    localparam logic [2:0] MODE_RISE = 3'h1;
    localparam logic [2:0] MODE_TOG_DB = 3'h2;
    localparam logic [2:0] MODE_RISE_DB = 3'h3;
    localparam logic [2:0] MODE_FALL = 3'h4;
    localparam logic [2:0] MODE_TOG = 3'h5;
    localparam logic [2:0] MODE_FALL_DB = 3'h6;
    localparam logic [2:0] MODE_HIGH = 3'h7;
    localparam int PERSIST_SAMPLES = 4;
    localparam logic [1:0] DEB_OVERFLOWS = 2'h2;
    localparam int NUM_CHANNELS = 4;

    typedef struct packed {
        logic [1:0] positive_channel_select;
        logic input_connect;
        logic event_flag;
        logic comparator_enable;
        logic [2:0] flag_condition_mode;
    } ctrl_reg_t;

    typedef struct packed {
        logic [3:0] unused;
        logic [1:0] reference_select;
        logic [1:0] sampling_source_select;
    } ref_reg_t;

    typedef enum logic {DEB_IDLE, DEB_WAIT} deb_state_t;
endpackage : cmp_event_pkg

// [logic/sync_two_ff.sv]
// Two flip-flop synchroniser for asynchronous levels
`timescale 1ns/10ps
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule : sync_two_ff

// [logic/persist_filter.sv]
// Accepts a level change only after consecutive agreeing samples
`timescale 1ns/10ps
module persist_filter #(
    parameter int COUNT = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic din,
    output logic dout
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT - 1);
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic out_ff;
    logic nxt_out;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_out = out_ff;
        if (tick) begin
            if (din == out_ff) begin
                nxt_cnt = '0;
            end else if (cnt_ff == LAST) begin
                nxt_out = din; // R07
                nxt_cnt = '0;
            end else begin
                nxt_cnt = cnt_ff + CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            out_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            out_ff <= nxt_out;
        end
    end

    assign dout = out_ff;
endmodule : persist_filter

// [logic/comparator_event_debouncer.sv]
// Comparator A event logic, debouncer and register slave
`timescale 1ns/10ps
module comparator_event_debouncer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [cmp_event_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [cmp_event_pkg::DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [cmp_event_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic comp_raw,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic timer2_overflow,
    output logic comp_out,
    output logic input_connect,
    output logic [1:0] positive_channel_select,
    output logic [1:0] reference_select,
    output logic [3:0] digital_input_disable,
    output logic irq
);
    import cmp_event_pkg::*;

    // Reset release
    logic [1:0] rst_sync_ff;
    logic rst_q_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_q_n = rst_sync_ff[1];

    // Comparator level, high when positive input exceeds negative
    logic comp_sync;
    sync_two_ff #(.WIDTH(1)) u_comp_sync (
        .clk(clk),
        .rst_n(rst_q_n),
        .din(comp_raw),
        .dout(comp_sync)
    ); // R16

    // Register state
    ctrl_reg_t ctrl_ff, nxt_ctrl;
    ref_reg_t ref_ff, nxt_ref;
    logic [7:0] ie_ff, nxt_ie;
    logic reject_ff, nxt_reject, wait_ff, nxt_wait;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic irq_ff, nxt_irq, comp_out_ff, nxt_comp_out;
    logic [3:0] dig_dis_ff, nxt_dig_dis;
    logic set_flag, set_reject;
    logic req, wr_take, flag_clr, rej_clr;
    logic [7:0] stat_view;

    assign req = read | write;
    assign wr_take = write & ~wait_ff & byteenable[0];
    assign stat_view = {1'b0, ctrl_ff.event_flag, 5'h00, reject_ff};
    assign flag_clr = wr_take & ((address == CTRL_ADDR
        && !writedata[FLAG_BIT])
        || (address == CLR_ADDR && writedata[IRQ_CMP_BIT]));
    assign rej_clr = wr_take & (address == CLR_ADDR) & writedata[IRQ_REJ_BIT];

    // Sampling source and persistence filter
    logic tick, tick_d_ff, nxt_tick_d, filt_out;
    logic clock_src;
    assign clock_src = (ref_ff.sampling_source_select == SRC_CLOCK);
    always_comb begin
        unique case (ref_ff.sampling_source_select)
            SRC_CLOCK: tick = 1'b1; // R01
            SRC_TIMER0: tick = timer0_overflow; // R17
            SRC_TIMER1: tick = timer1_overflow; // R17
            SRC_TIMER2: tick = timer2_overflow; // R17
        endcase
    end

    persist_filter #(.COUNT(PERSIST_SAMPLES)) u_persist (
        .clk(clk),
        .rst_n(rst_q_n),
        .tick(tick & ~clock_src),
        .din(comp_sync),
        .dout(filt_out)
    ); // R07

    // Sampled level and previous sample
    logic samp_ff, nxt_samp, prev_ff, nxt_prev, fresh_ff, nxt_fresh;
    logic en;
    assign en = ctrl_ff.comparator_enable;
    always_comb begin
        nxt_tick_d = tick & ~clock_src;
        nxt_samp = samp_ff;
        nxt_prev = prev_ff;
        nxt_fresh = 1'b0;
        if (!en) begin
            nxt_samp = 1'b0; // R13
            nxt_prev = 1'b0;
        end else if (clock_src) begin
            nxt_samp = comp_sync; // R01
            nxt_prev = samp_ff;
            nxt_fresh = 1'b1;
        end else if (tick_d_ff) begin
            nxt_samp = filt_out; // R07
            nxt_prev = samp_ff;
            nxt_fresh = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            tick_d_ff <= 1'b0;
            samp_ff <= 1'b0;
            prev_ff <= 1'b0;
            fresh_ff <= 1'b0;
        end else begin
            tick_d_ff <= nxt_tick_d;
            samp_ff <= nxt_samp;
            prev_ff <= nxt_prev;
            fresh_ff <= nxt_fresh;
        end
    end

    // Flag condition decode
    logic rise, fall, tog, debounced, cond_hit, db_edge;
    assign rise = samp_ff & ~prev_ff;
    assign fall = ~samp_ff & prev_ff;
    assign tog = samp_ff ^ prev_ff;
    always_comb begin
        cond_hit = 1'b0;
        db_edge = 1'b0;
        unique case (ctrl_ff.flag_condition_mode)
            MODE_LOW: cond_hit = ~samp_ff; // R18
            MODE_RISE: cond_hit = rise; // R18
            MODE_TOG_DB: db_edge = tog; // R02
            MODE_RISE_DB: db_edge = rise; // R02
            MODE_FALL: cond_hit = fall; // R18
            MODE_TOG: cond_hit = tog; // R18
            MODE_FALL_DB: db_edge = fall; // R02
            MODE_HIGH: cond_hit = samp_ff; // R18
        endcase
        debounced = (ctrl_ff.flag_condition_mode == MODE_TOG_DB)
            || (ctrl_ff.flag_condition_mode == MODE_RISE_DB)
            || (ctrl_ff.flag_condition_mode == MODE_FALL_DB);
        if (debounced && !clock_src) begin
            cond_hit = db_edge; // R07
        end
        cond_hit = cond_hit & fresh_ff & en; // R10
    end

    // Debounce timing on Timer 1 overflows
    deb_state_t st_ff, nxt_st;
    logic [1:0] ovf_cnt_ff, nxt_ovf_cnt;
    logic expect_ff, nxt_expect;
    logic db_set, db_drop;
    always_comb begin
        nxt_st = st_ff;
        nxt_ovf_cnt = ovf_cnt_ff;
        nxt_expect = expect_ff;
        db_set = 1'b0;
        db_drop = 1'b0;
        unique case (st_ff)
            DEB_IDLE: begin
                if (debounced && clock_src && db_edge && fresh_ff && en) begin
                    nxt_st = DEB_WAIT; // R03
                    nxt_ovf_cnt = 2'h0;
                    nxt_expect = samp_ff;
                end
            end
            DEB_WAIT: begin
                if (!en || !debounced || !clock_src) begin
                    nxt_st = DEB_IDLE; // R13
                end else if (timer1_overflow) begin
                    if (ovf_cnt_ff + 2'h1 == DEB_OVERFLOWS) begin
                        nxt_st = DEB_IDLE; // R04
                        db_set = (samp_ff == expect_ff); // R05
                        db_drop = (samp_ff != expect_ff); // R05
                    end else begin
                        nxt_ovf_cnt = ovf_cnt_ff + 2'h1; // R06
                    end
                end
            end
        endcase
    end
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            st_ff <= DEB_IDLE;
            ovf_cnt_ff <= 2'h0;
            expect_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            ovf_cnt_ff <= nxt_ovf_cnt;
            expect_ff <= nxt_expect;
        end
    end
    assign set_flag = cond_hit | db_set;
    assign set_reject = db_drop;

    // Register file and Avalon slave
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_ref = ref_ff;
        nxt_ie = ie_ff;
        nxt_reject = reject_ff;
        nxt_wait = 1'b1;
        nxt_rdata = rdata_ff;
        if (req && wait_ff) begin
            nxt_wait = 1'b0;
            unique case (address)
                CTRL_ADDR: nxt_rdata = {24'h0, ctrl_ff};
                REF_ADDR: nxt_rdata = {24'h0, ref_ff};
                STAT_ADDR: nxt_rdata = {24'h0, stat_view};
                IE_ADDR: nxt_rdata = {24'h0, ie_ff};
                default: nxt_rdata = 32'h0;
            endcase
        end
        if (wr_take) begin
            unique case (address)
                CTRL_ADDR: begin
                    nxt_ctrl = ctrl_reg_t'(writedata[7:0]);
                    nxt_ctrl.event_flag = ctrl_ff.event_flag;
                end
                REF_ADDR: nxt_ref = {4'h0, writedata[3:0]};
                IE_ADDR: nxt_ie = writedata[7:0];
                default: nxt_ie = ie_ff;
            endcase
        end
        if (flag_clr) begin
            nxt_ctrl.event_flag = 1'b0; // R11
        end
        if (rej_clr) begin
            nxt_reject = 1'b0;
        end
        if (set_flag) begin
            nxt_ctrl.event_flag = 1'b1; // R10
        end
        if (set_reject) begin
            nxt_reject = 1'b1;
        end
        nxt_irq = (nxt_ctrl.event_flag & nxt_ie[IRQ_CMP_BIT]) // R12
            | (nxt_reject & nxt_ie[IRQ_REJ_BIT]);
        nxt_dig_dis = {NUM_CHANNELS{nxt_ctrl.comparator_enable}}; // R14
        nxt_comp_out = nxt_ctrl.comparator_enable & nxt_samp; // R13
    end
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            ctrl_ff <= ctrl_reg_t'(CTRL_RESET); // R15
            ref_ff <= ref_reg_t'(REF_RESET);
            ie_ff <= IE_RESET;
            reject_ff <= 1'b0;
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0;
            irq_ff <= 1'b0;
            dig_dis_ff <= 4'h0;
            comp_out_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            ref_ff <= nxt_ref;
            ie_ff <= nxt_ie;
            reject_ff <= nxt_reject;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
            dig_dis_ff <= nxt_dig_dis;
            comp_out_ff <= nxt_comp_out;
        end
    end

    assign readdata = rdata_ff;
    assign waitrequest = wait_ff;
    assign irq = irq_ff;
    assign comp_out = comp_out_ff;
    assign input_connect = ctrl_ff.input_connect; // R08
    assign positive_channel_select = ctrl_ff.positive_channel_select; // R19
    assign reference_select = ref_ff.reference_select;
    assign digital_input_disable = dig_dis_ff;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_q_n);

    sequence s_arm;
        st_ff == DEB_IDLE ##1 st_ff == DEB_WAIT;
    endsequence
    sequence s_two_ovf;
        (st_ff == DEB_WAIT && timer1_overflow && ovf_cnt_ff == 2'h1);
    endsequence
    property p_every_clock;
        (clock_src && en) |=> (samp_ff == $past(comp_sync));
    endproperty
    a_every_clock: assert property (p_every_clock) // R01
        else $error("sample missed in clock source");
    property p_forced_low;
        !en |=> (!samp_ff && !comp_out_ff);
    endproperty
    a_forced_low: assert property (p_forced_low) // R13
        else $error("output not low while disabled");
    property p_flag_needs_en;
        $rose(ctrl_ff.event_flag) |-> $past(en);
    endproperty
    a_flag_needs_en: assert property (p_flag_needs_en) // R10
        else $error("flag set while disabled");
    property p_flag_sticky;
        (ctrl_ff.event_flag && !flag_clr) |=> ctrl_ff.event_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // R11
        else $error("flag cleared without software");
    property p_irq_gate;
        1'b1 |-> irq == ((ctrl_ff.event_flag & ie_ff[IRQ_CMP_BIT])
            | (reject_ff & ie_ff[IRQ_REJ_BIT]));
    endproperty
    a_irq_gate: assert property (p_irq_gate) // R12
        else $error("interrupt does not follow enable");
    property p_dig_disable;
        1'b1 |-> (digital_input_disable == {4{en}});
    endproperty
    a_dig_disable: assert property (p_dig_disable) // R14
        else $error("digital input paths wrong");
    property p_two_overflows;
        s_two_ovf |=> st_ff == DEB_IDLE;
    endproperty
    a_two_overflows: assert property (p_two_overflows) // R04
        else $error("debounce did not resample");
    property p_arm_zero;
        s_arm |-> ovf_cnt_ff == 2'h0;
    endproperty
    a_arm_zero: assert property (p_arm_zero) // R06
        else $error("debounce count not cleared");
    property p_db_flag;
        (clock_src && debounced && !ctrl_ff.event_flag && !cond_hit)
            ##1 $rose(ctrl_ff.event_flag) |-> $past(st_ff) == DEB_WAIT;
    endproperty
    a_db_flag: assert property (p_db_flag) // R05
        else $error("debounced flag without wait");
    property p_bus_answer;
        (req && wait_ff) |=> !waitrequest ##1 waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("waitrequest handshake wrong");
endmodule : comparator_event_debouncer

// [bench/cmp_far_side_model.sv]
// Far side model: analog comparator and free-running timers
`timescale 1ns/10ps
module cmp_far_side_model #(
    parameter int T0 = 7,
    parameter int T1 = 10,
    parameter int T2 = 13
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] pos_lvl,
    input wire logic [7:0] neg_lvl,
    output logic comp_raw,
    output logic timer0_overflow,
    output logic timer1_overflow,
    output logic timer2_overflow
);
    int c0;
    int c1;
    int c2;
    assign comp_raw = (pos_lvl > neg_lvl);
    assign timer0_overflow = (c0 == T0 - 1);
    assign timer1_overflow = (c1 == T1 - 1);
    assign timer2_overflow = (c2 == T2 - 1);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            c0 <= 0;
            c1 <= 0;
            c2 <= 0;
        end else begin
            c0 <= (c0 == T0 - 1) ? 0 : c0 + 1;
            c1 <= (c1 == T1 - 1) ? 0 : c1 + 1;
            c2 <= (c2 == T2 - 1) ? 0 : c2 + 1;
        end
    end
endmodule : cmp_far_side_model

// [bench/test_comparator_event_debouncer.sv]
// Self-checking bench for the comparator event logic
`timescale 1ns/10ps
module test_comparator_event_debouncer;
    import cmp_event_pkg::*;
    localparam int T0 = 7;
    localparam int T1 = 10;
    localparam int T2 = 13;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [DATA_W-1:0] writedata = '0;
    logic [3:0] byteenable = 4'h0;
    logic [DATA_W-1:0] readdata;
    logic waitrequest, comp_raw, t0, t1, t2, comp_out, input_connect, irq;
    logic [1:0] positive_channel_select, reference_select;
    logic [3:0] digital_input_disable;
    logic [7:0] pos_lvl = 8'h40;
    logic [7:0] neg_lvl = 8'h80;
    logic [7:0] rd;
    logic [2:0] exp_tab [8];
    int n_mismatch = 0;
    int n_checks = 0;
    int n;
    int p;

    comparator_event_debouncer u_dut (.clk(clk), .rst_n(rst_n),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .comp_raw(comp_raw), .timer0_overflow(t0), .timer1_overflow(t1),
        .timer2_overflow(t2), .comp_out(comp_out),
        .input_connect(input_connect),
        .positive_channel_select(positive_channel_select),
        .reference_select(reference_select),
        .digital_input_disable(digital_input_disable), .irq(irq));

    cmp_far_side_model #(.T0(T0), .T1(T1), .T2(T2)) u_far (.clk(clk),
        .rst_n(rst_n), .pos_lvl(pos_lvl), .neg_lvl(neg_lvl),
        .comp_raw(comp_raw), .timer0_overflow(t0), .timer1_overflow(t1),
        .timer2_overflow(t2));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wt(input int c);
        repeat (c) @(posedge clk);
    endtask : wt

    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [7:0] d, input logic [3:0] be);
        int k;
        k = 0;
        @(posedge clk);
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        read <= ~wr;
        write <= wr;
        do begin
            @(posedge clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 20);
        if (k >= 20) check("waitrequest answer", 0, 1);
        rd = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [7:0] e,
                         input string what);
        bus(1'b0, a, 8'h00, 4'h0);
        check(what, e, rd);
    endtask : rdchk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        exp_tab = '{3'h7, 3'h2, 3'h3, 3'h2, 3'h1, 3'h3, 3'h1, 3'h3};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        wt(4);
        rdchk(CTRL_ADDR, CTRL_RESET, "ctrl reset");
        rdchk(REF_ADDR, REF_RESET, "ref reset");
        rdchk(IE_ADDR, IE_RESET, "ie reset");
        rdchk(STAT_ADDR, 8'h00, "status reset");
        check("comp_out reset", 0, comp_out);
        wr(STAT_ADDR, 8'hff);
        rdchk(STAT_ADDR, 8'h00, "status read only");
        rdchk(CLR_ADDR, 8'h00, "clear reads zero");
        rdchk(12'h004, 8'h00, "unmapped read");
        bus(1'b1, CTRL_ADDR, 8'hff, 4'h0);
        rdchk(CTRL_ADDR, 8'h00, "byteenable off");
        $display("test reset values done");
        for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
            wr(CTRL_ADDR, 8'h08);
            wr(REF_ADDR, {4'h0, ch[1:0], 2'h0});
            wr(CTRL_ADDR, {ch[1:0], 6'h08});
            wr(CTRL_ADDR, {ch[1:0], 6'h28});
            wt(2);
            check("channel", ch[1:0], positive_channel_select);
            check("reference", ch[1:0], reference_select);
            check("connect on", 1, input_connect);
            check("digital off", 4'hf, digital_input_disable);
            rdchk(CTRL_ADDR, {ch[1:0], 6'h38}, "ctrl readback");
        end
        wr(CTRL_ADDR, 8'h00);
        wt(2);
        check("connect off", 0, input_connect);
        check("digital on", 0, digital_input_disable);
        $display("test channels done");
        wr(REF_ADDR, {6'h0, SRC_CLOCK});
        wr(IE_ADDR, 8'h40);
        for (int m = 0; m < 8; m++) begin
            wr(CTRL_ADDR, {5'h05, m[2:0]});
            wt(40);
            wr(CLR_ADDR, 8'h40);
            wt(6);
            rdchk(STAT_ADDR, {1'b0, exp_tab[m][2], 6'h0}, "flag low");
            @(posedge clk);
            pos_lvl <= 8'hc0;
            wt(40);
            rdchk(STAT_ADDR, {1'b0, exp_tab[m][1], 6'h0}, "flag rise");
            check("comp_out high", 1, comp_out);
            check("irq follows flag", exp_tab[m][1], irq);
            wr(CLR_ADDR, 8'h40);
            wt(6);
            @(posedge clk);
            pos_lvl <= 8'h40;
            wt(40);
            rdchk(STAT_ADDR, {1'b0, exp_tab[m][0], 6'h0}, "flag fall");
        end
        $display("test modes done");
        wr(CTRL_ADDR, 8'h2b);
        wr(CLR_ADDR, 8'h41);
        @(posedge clk);
        pos_lvl <= 8'hc0;
        wt(3);
        pos_lvl <= 8'h40;
        wt(40);
        rdchk(STAT_ADDR, 8'h01, "debounce reject");
        wr(IE_ADDR, 8'h41);
        wt(2);
        check("reject irq", 1, irq);
        wr(IE_ADDR, 8'h40);
        wt(2);
        check("reject irq masked", 0, irq);
        wr(CLR_ADDR, 8'h01);
        n = 0;
        @(posedge clk);
        pos_lvl <= 8'hc0;
        while (irq !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        check("debounce delay", 1, (n >= T1) && (n <= 2 * T1 + 8));
        pos_lvl <= 8'h40;
        $display("test debounce done");
        wr(CTRL_ADDR, 8'h29);
        for (int s = 1; s < 4; s++) begin
            p = (s == 1) ? T0 : (s == 2) ? T1 : T2;
            wr(REF_ADDR, {6'h0, s[1:0]});
            wt(8 * p);
            wr(CLR_ADDR, 8'h40);
            @(posedge clk);
            pos_lvl <= 8'hc0;
            wt(2 * p);
            pos_lvl <= 8'h40;
            wt(8 * p);
            rdchk(STAT_ADDR, 8'h00, "short change");
            @(posedge clk);
            pos_lvl <= 8'hc0;
            wt(6 * p);
            rdchk(STAT_ADDR, 8'h40, "lasting change");
            @(posedge clk);
            pos_lvl <= 8'h40;
        end
        $display("test timer sources done");
        wr(REF_ADDR, {6'h0, SRC_CLOCK});
        wr(CTRL_ADDR, 8'h27);
        @(posedge clk);
        pos_lvl <= 8'hc0;
        wt(10);
        check("comp_out disabled", 0, comp_out);
        check("irq disabled", 0, irq);
        rdchk(STAT_ADDR, 8'h00, "disabled no event");
        $display("test disable done");
        give_verdict();
    end
endmodule : test_comparator_event_debouncer
